// ---- logic/dtm_timer.sv ----
// Dual cascadable 8-bit timer, event counter and divider with APB access
//
// Register access over APB and the address map were decided locally.
module dtm_timer (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] count_input_pin,
	input wire logic low_freq_clock,
	output logic [1:0] match_irq,
	output logic [1:0] divider_out_pin,
	output logic [1:0] pwm_out_pin,
	output logic pulse_gen_out_pin
);

	typedef struct packed {
		dtm_pkg::dtm_ctl_t [1:0] ctl;
		logic [1:0][7:0] cmp;
		logic [1:0][7:0] duty;
		logic [1:0] cfg;
		logic [1:0][7:0] cnt;
		logic [1:0] ff;
		logic [1:0] pin_d;
		logic [1:0] irq;
		logic [31:0] rdata;
		logic err;
	} dtm_state_t;

	dtm_state_t st_r;
	dtm_state_t st_nxt;
	dtm_pkg::dtm_taps_t taps;
	dtm_pkg::dtm_apb_req_t req;
	logic [1:0] pin_fall;
	logic [1:0] tick;
	logic cascade;
	logic low_speed;
	logic slow_opt;

	// ==========================================================
	// Prescaler
	dtm_prescaler u_pre (
		.mclk(mclk),
		.reset_n(reset_n),
		.low_freq_clock(low_freq_clock),
		.taps(taps)
	);

	// ==========================================================
	// Helper functions
	function automatic logic tap_pick(
		input logic [2:0] sel,
		input dtm_pkg::dtm_taps_t t,
		input logic slow,
		input logic lspd,
		input logic pfall
	);
		logic r;
		r = 1'b0;
		// fast taps gated in low speed
		case (sel)
			dtm_pkg::CK_SLOWEST: r = (slow | lspd) ? t.fs8 : t.fc2048;
			dtm_pkg::CK_FC128: r = ~lspd & t.fc128;
			dtm_pkg::CK_FC32: r = ~lspd & t.fc32;
			dtm_pkg::CK_FC8: r = ~lspd & t.fc8;
			dtm_pkg::CK_FS: r = t.fs1;
			dtm_pkg::CK_FC2: r = ~lspd & t.fc2;
			dtm_pkg::CK_FC: r = ~lspd & t.fc1;
			dtm_pkg::CK_PIN: r = pfall;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic [1:0] reg_sel(input logic [7:0] a);
		logic [1:0] r;
		r = 2'h0;
		if (a == dtm_pkg::OFS_CTL_HI || a == dtm_pkg::OFS_CMP_HI ||
			a == dtm_pkg::OFS_DUTY_HI)
		begin
			r = 2'h2;
		end
		else if (a == dtm_pkg::OFS_CTL_LO || a == dtm_pkg::OFS_CMP_LO ||
			a == dtm_pkg::OFS_DUTY_LO)
		begin
			r = 2'h1;
		end
		return r;
	endfunction

	// ==========================================================
	// Inputs and tick selection
	assign req.psel = psel;
	assign req.penable = penable;
	assign req.pwrite = pwrite;
	assign req.paddr = paddr;
	assign req.pwdata = pwdata;

	assign slow_opt = st_r.cfg[dtm_pkg::CFG_SLOW_OPT_BIT];
	assign low_speed = st_r.cfg[dtm_pkg::CFG_LOW_SPEED_BIT];
	assign pin_fall = st_r.pin_d & ~count_input_pin;
	// upper mode 1xx chains both counters
	assign cascade = st_r.ctl[1].mode_field[2];

	// both halves use the lower clock select when chained
	assign tick[0] = tap_pick(st_r.ctl[0].clock_select, taps, slow_opt,
		low_speed, pin_fall[0]);
	assign tick[1] = tap_pick(st_r.ctl[1].clock_select, taps, slow_opt,
		low_speed, pin_fall[1]);

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		logic [1:0] sel;
		logic wr;
		logic rd;
		logic [7:0] inc;
		logic [15:0] c16;
		logic [15:0] n16;
		logic [15:0] cmp16;
		logic [15:0] duty16;
		dtm_pkg::dtm_ctl_t wctl;
		sel = 2'h0;
		wr = 1'b0;
		rd = 1'b0;
		inc = 8'h00;
		c16 = 16'h0000;
		n16 = 16'h0000;
		cmp16 = 16'h0000;
		duty16 = 16'h0000;
		wctl = dtm_pkg::dtm_ctl_t'(req.pwdata[7:0]);
		st_nxt = st_r;
		st_nxt.irq = 2'h0;
		st_nxt.pin_d = count_input_pin;

		// Counters of the 8-bit channels
		for (int i = 0; i < 2; i++)
		begin
			inc = st_r.cnt[i] + 8'h01;
			if (!cascade && !st_r.ctl[i].run_control_bit)
			begin
				st_nxt.cnt[i] = 8'h00;
			end
			else if (!cascade && tick[i])
			begin
				case (st_r.ctl[i].mode_field)
					dtm_pkg::MODE_TMR8, dtm_pkg::MODE_DIV8:
					begin
						if (inc == st_r.cmp[i])
						begin
							st_nxt.cnt[i] = 8'h00;
							st_nxt.irq[i] = 1'b1;
							if (st_r.ctl[i].mode_field == dtm_pkg::MODE_DIV8)
							begin
								st_nxt.ff[i] = ~st_r.ff[i];
							end
						end
						else
						begin
							st_nxt.cnt[i] = inc;
						end
					end
					dtm_pkg::MODE_PWM8:
					begin
						st_nxt.cnt[i] = inc;
						if (st_r.cnt[i] == dtm_pkg::CNT_MAX)
						begin
							st_nxt.ff[i] = ~st_r.ff[i];
							st_nxt.irq[i] = 1'b1;
						end
						else if (inc == st_r.duty[i])
						begin
							st_nxt.ff[i] = ~st_r.ff[i];
						end
					end
					default:
					begin
						st_nxt.cnt[i] = st_r.cnt[i];
					end
				endcase
			end
		end

		// Chained 16-bit counter
		c16 = {st_r.cnt[1], st_r.cnt[0]};
		n16 = c16 + 16'h0001;
		cmp16 = {st_r.cmp[1], st_r.cmp[0]};
		duty16 = {st_r.duty[1], st_r.duty[0]};
		if (cascade && st_r.ctl[1].run_control_bit && tick[0])
		begin
			{st_nxt.cnt[1], st_nxt.cnt[0]} = n16;
			case (st_r.ctl[1].mode_field)
				dtm_pkg::MODE_TMR16, dtm_pkg::MODE_WARM16:
				begin
					if (n16 == cmp16)
					begin
						{st_nxt.cnt[1], st_nxt.cnt[0]} = 16'h0000;
						st_nxt.irq[1] = 1'b1;
					end
				end
				dtm_pkg::MODE_PWM16:
				begin
					if (c16 == dtm_pkg::CNT16_MAX)
					begin
						st_nxt.ff[1] = ~st_r.ff[1];
						st_nxt.irq[1] = 1'b1;
					end
					else if (n16 == duty16)
					begin
						st_nxt.ff[1] = ~st_r.ff[1];
					end
				end
				dtm_pkg::MODE_PGEN16:
				begin
					if (n16 == cmp16)
					begin
						{st_nxt.cnt[1], st_nxt.cnt[0]} = 16'h0000;
						st_nxt.ff[1] = ~st_r.ff[1];
						st_nxt.irq[1] = 1'b1;
					end
					else if (n16 == duty16)
					begin
						st_nxt.ff[1] = ~st_r.ff[1];
					end
				end
				default:
				begin
					{st_nxt.cnt[1], st_nxt.cnt[0]} = c16;
				end
			endcase
		end
		else if (cascade && !st_r.ctl[1].run_control_bit)
		begin
			{st_nxt.cnt[1], st_nxt.cnt[0]} = 16'h0000;
		end

		// APB access
		wr = req.psel & req.penable & req.pwrite;
		rd = req.psel & ~req.penable & ~req.pwrite;
		sel = reg_sel(req.paddr);
		if (req.psel && !req.penable)
		begin
			st_nxt.err = 1'b0;
			st_nxt.rdata = 32'h0000_0000;
			case (req.paddr)
				dtm_pkg::OFS_CTL_LO: st_nxt.rdata[7:0] = st_r.ctl[0];
				dtm_pkg::OFS_CTL_HI: st_nxt.rdata[7:0] = st_r.ctl[1];
				dtm_pkg::OFS_CMP_LO: st_nxt.rdata[7:0] = st_r.cmp[0];
				dtm_pkg::OFS_CMP_HI: st_nxt.rdata[7:0] = st_r.cmp[1];
				dtm_pkg::OFS_DUTY_LO: st_nxt.rdata[7:0] = st_r.duty[0];
				dtm_pkg::OFS_DUTY_HI: st_nxt.rdata[7:0] = st_r.duty[1];
				dtm_pkg::OFS_CFG: st_nxt.rdata[1:0] = st_r.cfg;
				dtm_pkg::OFS_STATUS:
				begin
					st_nxt.rdata[15:0] = {st_r.cnt[1], st_r.cnt[0]};
					st_nxt.rdata[dtm_pkg::STAT_FF_LO_BIT] = st_r.ff[0];
					st_nxt.rdata[dtm_pkg::STAT_FF_HI_BIT] = st_r.ff[1];
				end
				default: st_nxt.err = 1'b1;
			endcase
			if (!rd)
			begin
				st_nxt.rdata = 32'h0000_0000;
			end
		end
		if (wr && !st_r.err)
		begin
			case (req.paddr)
				dtm_pkg::OFS_CTL_LO, dtm_pkg::OFS_CTL_HI:
				begin
					st_nxt.ctl[sel[1]] = wctl;
					// stopped or stopping flip-flop takes init bit
					if (!st_r.ctl[sel[1]].run_control_bit ||
						!wctl.run_control_bit)
					begin
						st_nxt.ff[sel[1]] = wctl.flip_flop_init_bit;
					end
				end
				// compare write takes effect at once
				dtm_pkg::OFS_CMP_LO, dtm_pkg::OFS_CMP_HI:
					st_nxt.cmp[sel[1]] = req.pwdata[7:0];
				dtm_pkg::OFS_DUTY_LO, dtm_pkg::OFS_DUTY_HI:
					st_nxt.duty[sel[1]] = req.pwdata[7:0];
				dtm_pkg::OFS_CFG: st_nxt.cfg = req.pwdata[1:0];
				default: st_nxt.cfg = st_r.cfg;
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_r <= '0;
			st_r.ctl[0] <= dtm_pkg::CTL_RESET;
			st_r.ctl[1] <= dtm_pkg::CTL_RESET;
			st_r.cmp[0] <= dtm_pkg::CMP_RESET;
			st_r.cmp[1] <= dtm_pkg::CMP_RESET;
			st_r.duty[0] <= dtm_pkg::DUTY_RESET;
			st_r.duty[1] <= dtm_pkg::DUTY_RESET;
			st_r.cfg <= dtm_pkg::CFG_RESET;
			st_r.pin_d <= 2'h3;
			st_r.ff <= 2'h0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign prdata = st_r.rdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & st_r.err;
	assign match_irq = st_r.irq;
	assign divider_out_pin = ~st_r.ff;
	assign pwm_out_pin = ~st_r.ff;
	assign pulse_gen_out_pin = ~st_r.ff[1];

endmodule

// ---- logic/dtm_pkg.sv ----
// Package of constants and types for the dual 8-bit timer block
package dtm_pkg;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CTL_LO = 8'h00;
	localparam logic [7:0] OFS_CTL_HI = 8'h04;
	localparam logic [7:0] OFS_CMP_LO = 8'h08;
	localparam logic [7:0] OFS_CMP_HI = 8'h0C;
	localparam logic [7:0] OFS_DUTY_LO = 8'h10;
	localparam logic [7:0] OFS_DUTY_HI = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_CFG = 8'h1C;

	// ==========================================================
	// Field positions and reset values
	localparam int CFG_SLOW_OPT_BIT = 0;
	localparam int CFG_LOW_SPEED_BIT = 1;
	localparam int STAT_FF_LO_BIT = 16;
	localparam int STAT_FF_HI_BIT = 17;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] CMP_RESET = 8'hFF;
	localparam logic [7:0] DUTY_RESET = 8'h80;
	localparam logic [1:0] CFG_RESET = 2'h0;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [15:0] CNT16_MAX = 16'hFFFF;

	// ==========================================================
	// Prescaler taps
	localparam int DIV_BITS = 11;
	localparam int FS_DIV_BITS = 3;

	// ==========================================================
	// Mode and clock select encodings
	localparam logic [2:0] MODE_TMR8 = 3'h0;
	localparam logic [2:0] MODE_DIV8 = 3'h1;
	localparam logic [2:0] MODE_PWM8 = 3'h2;
	localparam logic [2:0] MODE_CASC_LO = 3'h3;
	localparam logic [2:0] MODE_TMR16 = 3'h4;
	localparam logic [2:0] MODE_WARM16 = 3'h5;
	localparam logic [2:0] MODE_PWM16 = 3'h6;
	localparam logic [2:0] MODE_PGEN16 = 3'h7;
	localparam logic [2:0] CK_SLOWEST = 3'h0;
	localparam logic [2:0] CK_FC128 = 3'h1;
	localparam logic [2:0] CK_FC32 = 3'h2;
	localparam logic [2:0] CK_FC8 = 3'h3;
	localparam logic [2:0] CK_FS = 3'h4;
	localparam logic [2:0] CK_FC2 = 3'h5;
	localparam logic [2:0] CK_FC = 3'h6;
	localparam logic [2:0] CK_PIN = 3'h7;

	// ==========================================================
	// Types
	typedef struct packed {
		logic flip_flop_init_bit;
		logic [2:0] clock_select;
		logic run_control_bit;
		logic [2:0] mode_field;
	} dtm_ctl_t;

	typedef struct packed {
		logic fc1;
		logic fc2;
		logic fc8;
		logic fc32;
		logic fc128;
		logic fc2048;
		logic fs1;
		logic fs8;
	} dtm_taps_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} dtm_apb_req_t;

endpackage

// ---- logic/dtm_prescaler.sv ----
// Prescaler producing the one-cycle tap pulses for both counters
module dtm_prescaler (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic low_freq_clock,
	output dtm_pkg::dtm_taps_t taps
);

	typedef struct packed {
		logic [dtm_pkg::DIV_BITS-1:0] div;
		logic fs_d;
		logic [dtm_pkg::FS_DIV_BITS-1:0] fs_div;
	} dtm_pre_state_t;

	dtm_pre_state_t st_r;
	dtm_pre_state_t st_nxt;
	logic fs_edge;

	// ==========================================================
	// Edge of the low-frequency clock
	assign fs_edge = low_freq_clock & ~st_r.fs_d;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.div = st_r.div + 1'b1;
		st_nxt.fs_d = low_freq_clock;
		if (fs_edge)
		begin
			st_nxt.fs_div = st_r.fs_div + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Tap pulses
	// tap dividers
	assign taps.fc1 = 1'b1;
	assign taps.fc2 = st_r.div[0];
	assign taps.fc8 = &st_r.div[2:0];
	assign taps.fc32 = &st_r.div[4:0];
	assign taps.fc128 = &st_r.div[6:0];
	assign taps.fc2048 = &st_r.div[10:0];
	assign taps.fs1 = fs_edge;
	assign taps.fs8 = fs_edge & (&st_r.fs_div);

endmodule

// ---- bench/dtm_timer_sva.sv ----
// Port-level checker of the dual timer
module dtm_timer_sva (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] match_irq,
	input wire logic [1:0] divider_out_pin,
	input wire logic [1:0] pwm_out_pin,
	input wire logic pulse_gen_out_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Bus phases
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	sequence acc_s;
		psel && penable;
	endsequence
	sequence acc_end_s;
		acc_s ##1 !psel;
	endsequence
	pready_high_a:
		assert property (pready) else $error("pready low");
	err_phase_a:
		assert property (pslverr |-> acc_s) else $error("stray error");
	unmapped_err_a:
		assert property (psel && penable && paddr > 8'h1C |-> pslverr)
			else $error("unmapped not refused");
	mapped_ok_a:
		assert property (psel && penable && paddr <= 8'h1C
			&& paddr[1:0] == 2'h0 |-> !pslverr) else $error("bad error");
	rd_hold_a:
		assert property (acc_end_s |-> $stable(prdata))
			else $error("read data moved");
	// ==========
	// Pins
	pins_reset_a:
		assert property ($rose(reset_n) |-> divider_out_pin == 2'h3
			&& match_irq == 2'h0) else $error("pins not reset");
	pwm_same_a:
		assert property (pwm_out_pin == divider_out_pin)
			else $error("pwm pin differs");
	pgen_pin_a:
		assert property (pulse_gen_out_pin == divider_out_pin[1])
			else $error("pulse pin differs");
endmodule

bind dtm_timer dtm_timer_sva chk (.mclk, .reset_n, .psel, .penable,
	.paddr, .prdata, .pready, .pslverr, .match_irq, .divider_out_pin,
	.pwm_out_pin, .pulse_gen_out_pin);

// ---- bench/dtm_pin_src.sv ----
// Model of the event pulse source and low-frequency clock
module dtm_pin_src (
	input wire logic mclk,
	output logic [1:0] count_input_pin,
	output logic low_freq_clock
);
	timeunit 1ns;
	timeprecision 1ps;
	int k;
	initial
	begin
		count_input_pin = 2'h3;
		low_freq_clock = 1'b0;
		k = 0;
	end
	// Free-running slow clock, ten cycles
	always @(posedge mclk)
	begin
		k <= (k == 4) ? 0 : k + 1;
		if (k == 4)
			low_freq_clock <= ~low_freq_clock;
	end
	task automatic pulses(input int b, input int cnt);
		repeat (cnt)
		begin
			repeat (8) @(posedge mclk);
			count_input_pin[b] <= 1'b0;
			repeat (8) @(posedge mclk);
			count_input_pin[b] <= 1'b1;
		end
		repeat (8) @(posedge mclk);
	endtask
endmodule

// ---- bench/test_dtm_timer.sv ----
// Self-checking bench of the dual timer
module test_dtm_timer;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, er, lfc, pg;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] cin, irq, dpin, ppin;
	int miscompares, checks_done, icnt, n, m;
	dtm_timer dut (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .count_input_pin(cin),
		.low_freq_clock(lfc), .match_irq(irq), .divider_out_pin(dpin),
		.pwm_out_pin(ppin), .pulse_gen_out_pin(pg));
	// port latch taken as set; pins observed directly
	dtm_pin_src src (.mclk, .count_input_pin(cin), .low_freq_clock(lfc));
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk)
		if (irq[0] === 1'b1)
			icnt <= icnt + 1;
	// ==========
	// Helpers
	task chk(input logic [31:0] g, input logic [31:0] e, input string s);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %0t %s", $time, s);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge mclk);
			i++;
		end
		while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1)
		begin
			miscompares++;
			$display("[FAIL] %0t no ready", $time);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function logic [31:0] cw(logic f, logic [2:0] s, logic r, logic [2:0] md);
		return {24'h0, f, s, r, md};
	endfunction
	task period(input int b);
		int i;
		i = 0;
		n = 0;
		while (irq[b] !== 1'b1 && i < 3000)
		begin
			@(posedge mclk);
			i++;
		end
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (irq[b] !== 1'b1 && n < 3000);
	endtask
	task half;
		logic p;
		int i;
		i = 0;
		n = 0;
		@(posedge mclk);
		p = dpin[0];
		while (dpin[0] === p && i < 3000)
		begin
			@(posedge mclk);
			i++;
		end
		p = dpin[0];
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (dpin[0] === p && n < 3000);
	endtask
	task lo(input logic [31:0] c);
		apb(1'b1, dtm_pkg::OFS_CTL_LO, c);
	endtask
	task hi(input logic [31:0] c);
		apb(1'b1, dtm_pkg::OFS_CTL_HI, c);
	endtask
	task lows(input int w, input logic s);
		m = 0;
		repeat (w)
		begin
			@(posedge mclk);
			if ((s ? pg : ppin[0]) === 1'b0)
				m++;
		end
	endtask
	// ==========
	// Scenarios
	task t_reset;
		apb(1'b0, dtm_pkg::OFS_CMP_LO, 32'h0);
		chk(rd, {24'h0, dtm_pkg::CMP_RESET}, "cmp reset");
		apb(1'b0, dtm_pkg::OFS_DUTY_LO, 32'h0);
		chk(rd, {24'h0, dtm_pkg::DUTY_RESET}, "duty reset");
		apb(1'b0, dtm_pkg::OFS_CTL_HI, 32'h0);
		chk(rd, 32'h0, "ctl reset");
		chk(32'({dpin, pg}), 32'h7, "pins reset");
		apb(1'b1, 8'h20, 32'h1);
		chk(32'(er), 32'h1, "unmapped");
	endtask
	task t_timer;
		apb(1'b1, dtm_pkg::OFS_CMP_LO, 32'h3);
		lo(cw(1'b0, dtm_pkg::CK_FC, 1'b1, dtm_pkg::MODE_TMR8));
		period(0);
		chk(32'(n), 32'h3, "timer interval");
		apb(1'b1, dtm_pkg::OFS_CMP_LO, 32'h5);
		period(0);
		chk(32'(n), 32'h5, "cmp rewrite");
		lo(cw(1'b0, dtm_pkg::CK_FC, 1'b0, dtm_pkg::MODE_TMR8));
		apb(1'b0, dtm_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'hFF, 32'h0, "stop clears");
		m = icnt;
		repeat (20) @(posedge mclk);
		chk(32'(icnt), 32'(m), "stopped irq");
	endtask
	task t_div;
		apb(1'b1, dtm_pkg::OFS_CMP_LO, 32'h4);
		lo(cw(1'b0, dtm_pkg::CK_FC, 1'b1, dtm_pkg::MODE_DIV8));
		repeat (2)
		begin
			half;
			chk(32'(n), 32'h4, "half period");
		end
		lo(cw(1'b0, dtm_pkg::CK_FC, 1'b0, dtm_pkg::MODE_DIV8));
		repeat (3) @(posedge mclk);
		apb(1'b0, dtm_pkg::OFS_STATUS, 32'h0);
		chk(32'(rd[16]), {31'h0, ~dpin[0]}, "pin inverse");
		lo(cw(1'b1, dtm_pkg::CK_FC, 1'b0, dtm_pkg::MODE_DIV8));
		repeat (3) @(posedge mclk);
		chk(32'(dpin[0]), 32'h0, "init one");
		lo(cw(1'b0, dtm_pkg::CK_FC, 1'b0, dtm_pkg::MODE_DIV8));
		repeat (3) @(posedge mclk);
		chk(32'(dpin[0]), 32'h1, "init zero");
	endtask
	task t_event;
		apb(1'b1, dtm_pkg::OFS_CMP_LO, 32'h2);
		lo(cw(1'b0, dtm_pkg::CK_PIN, 1'b1, dtm_pkg::MODE_TMR8));
		m = icnt;
		src.pulses(0, 1);
		chk(32'(icnt), 32'(m), "early irq");
		apb(1'b0, dtm_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'hFF, 32'h1, "edge count");
		src.pulses(0, 1);
		chk(32'(icnt), 32'(m + 1), "event match");
		src.pulses(0, 2);
		chk(32'(icnt), 32'(m + 2), "event resume");
		lo(cw(1'b0, dtm_pkg::CK_PIN, 1'b0, dtm_pkg::MODE_TMR8));
	endtask
	task t_pwm;
		apb(1'b1, dtm_pkg::OFS_DUTY_LO, 32'h2);
		lo(cw(1'b0, dtm_pkg::CK_FC, 1'b1, dtm_pkg::MODE_PWM8));
		period(0);
		chk(32'(n), 32'h100, "pwm period");
		lows(256, 1'b0);
		chk(32'(m), 32'hFE, "pwm low time");
		lo(cw(1'b0, dtm_pkg::CK_FC, 1'b0, dtm_pkg::MODE_PWM8));
	endtask
	task t_casc;
		apb(1'b1, dtm_pkg::OFS_CMP_LO, 32'h2);
		apb(1'b1, dtm_pkg::OFS_CMP_HI, 32'h1);
		lo(cw(1'b0, dtm_pkg::CK_FC, 1'b0, dtm_pkg::MODE_CASC_LO));
		hi(cw(1'b0, dtm_pkg::CK_SLOWEST, 1'b1, dtm_pkg::MODE_TMR16));
		period(1);
		chk(32'(n), 32'h102, "cascade interval");
		hi(cw(1'b0, dtm_pkg::CK_SLOWEST, 1'b0, dtm_pkg::MODE_TMR16));
		apb(1'b1, dtm_pkg::OFS_CMP_LO, 32'h10);
		apb(1'b1, dtm_pkg::OFS_CMP_HI, 32'h0);
		apb(1'b1, dtm_pkg::OFS_DUTY_LO, 32'h4);
		apb(1'b1, dtm_pkg::OFS_DUTY_HI, 32'h0);
		hi(cw(1'b0, dtm_pkg::CK_SLOWEST, 1'b1, dtm_pkg::MODE_PGEN16));
		period(1);
		chk(32'(n), 32'h10, "pulse period");
		lows(16, 1'b1);
		chk(32'(m), 32'hC, "pulse width");
		hi(cw(1'b0, dtm_pkg::CK_SLOWEST, 1'b0, dtm_pkg::MODE_PGEN16));
		hi(cw(1'b0, dtm_pkg::CK_SLOWEST, 1'b0, dtm_pkg::MODE_TMR8));
	endtask
	task t_rst2;
		lo(cw(1'b1, dtm_pkg::CK_FC, 1'b0, dtm_pkg::MODE_TMR8));
		repeat (2) @(posedge mclk);
		chk(32'(dpin[0]), 32'h0, "ff set");
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (2) @(posedge mclk);
		chk(32'({dpin, pg}), 32'h7, "ff reset");
	endtask
	task t_taps;
		apb(1'b1, dtm_pkg::OFS_CMP_LO, 32'h2);
		for (int i = 0; i < 3; i++)
		begin
			lo(cw(1'b0, 3'(i + 1), 1'b1, dtm_pkg::MODE_TMR8));
			period(0);
			chk(32'(n), 32'h2 << (7 - 2 * i), "fast tap");
			lo(cw(1'b0, 3'(i + 1), 1'b0, dtm_pkg::MODE_TMR8));
		end
		for (int c = 1; c < 3; c++)
		begin
			apb(1'b1, dtm_pkg::OFS_CFG, 32'(c));
			lo(cw(1'b0, dtm_pkg::CK_SLOWEST, 1'b1, dtm_pkg::MODE_TMR8));
			period(0);
			chk(32'(n), 32'hA0, "slow tap");
			lo(cw(1'b0, dtm_pkg::CK_SLOWEST, 1'b0, dtm_pkg::MODE_TMR8));
		end
		lo(cw(1'b0, dtm_pkg::CK_FC8, 1'b1, dtm_pkg::MODE_TMR8));
		m = icnt;
		repeat (100) @(posedge mclk);
		chk(32'(icnt), 32'(m), "fast tap off");
		lo(cw(1'b0, dtm_pkg::CK_FC8, 1'b0, dtm_pkg::MODE_TMR8));
	endtask
	task results;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#400000;
		miscompares++;
		results;
	end
	initial
	begin
		{psel, penable, pwrite, reset_n} = 4'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		{miscompares, checks_done, icnt} = '0;
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		t_reset;
		t_timer;
		t_div;
		t_event;
		t_pwm;
		t_casc;
		t_taps;
		t_rst2;
		results;
	end
endmodule
